/* chip_reset_pkg.sv */
// constants, timing counts and the sequencer state type for the chip reset sequencer
// assumes a 100 MHz internal clock; the 32 MHz reference only feeds the two PLLs
package chip_reset_pkg;

    // clocking
    localparam int CLK_PERIOD_PS = 10000;
    localparam int REF_CLK_KHZ = 32000;
    localparam int PLL_COUNT = 2;

    // synchroniser depth for every pin-level input
    localparam int SYNC_STAGES = 2;

    // release stretch after an external reset goes away (a longest time)
    localparam int STRETCH_MAX_PS = 173600;
    localparam int STRETCH_TOTAL_CYC = STRETCH_MAX_PS / CLK_PERIOD_PS;
    localparam int STRETCH_CNT_W = 4;
    // synchroniser and output flop already spend part of the budget
    localparam logic [STRETCH_CNT_W-1:0] STRETCH_HOLD_CYC =
        STRETCH_CNT_W'(STRETCH_TOTAL_CYC - SYNC_STAGES - 1);
    localparam logic [STRETCH_CNT_W-1:0] STRETCH_CNT_ZERO = 4'h0;

    // figures the outside parties must keep
    localparam int SUPPLY_RESET_MIN_WIDTH_US = 50;
    localparam int DEBUGGER_RESET_MIN_WIDTH_NS = 10;

    // PLL lock must be reached within this time (a longest time, rounds down)
    localparam int PLL_LOCK_MAX_US = 50;
    localparam int PLL_LOCK_MAX_CYC = PLL_LOCK_MAX_US * 1000000 / CLK_PERIOD_PS;
    localparam int LOCK_CNT_W = 16;
    localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_RST = 16'h0000;

    // watchdog
    localparam int WDOG_CNT_W = 16;
    localparam logic [WDOG_CNT_W-1:0] WDOG_CNT_RST = 16'h0000;

    typedef enum logic [1:0] {
        SEQ_POWER_HOLD = 2'h0,
        SEQ_CORE_HOLD = 2'h1,
        SEQ_RUN = 2'h3
    } seq_state_t;

endpackage

/* level_release_sync.sv */
// reset synchroniser: asserts at once with its pin, releases after SYNC_STAGES edges
// assumes the async input is active low and glitch free
`timescale 1ns/10ps
module level_release_sync (
    input wire logic i_sys_clk,
    input wire logic i_async_rst_n,
    output logic o_active
);
    import chip_reset_pkg::*;

    logic [SYNC_STAGES-1:0] sync_q;
    logic [SYNC_STAGES-1:0] sync_d;

    // only the last stage is ever looked at
    always_comb begin
        sync_d = {sync_q[SYNC_STAGES-2:0], 1'b0};
    end

    always_ff @(posedge i_sys_clk or negedge i_async_rst_n) begin
        if (!i_async_rst_n) begin
            sync_q <= '1;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign o_active = sync_q[SYNC_STAGES-1];
endmodule

/* release_stretch.sv */
// reset stretcher: async assertion, clocked release STRETCH_HOLD_CYC+1 edges after hold drops
// assumes i_hold is already synchronous to i_sys_clk
`timescale 1ns/10ps
module release_stretch (
    input wire logic i_sys_clk,
    input wire logic i_async_rst_n,
    input wire logic i_hold,
    output logic o_active
);
    import chip_reset_pkg::*;

    logic [STRETCH_CNT_W-1:0] cnt_q;
    logic [STRETCH_CNT_W-1:0] cnt_d;
    logic active_q;
    logic active_d;

    always_comb begin
        cnt_d = cnt_q;
        if (i_hold) begin
            cnt_d = STRETCH_HOLD_CYC;
        end else if (cnt_q != STRETCH_CNT_ZERO) begin
            cnt_d = cnt_q - 4'h1;
        end
        active_d = i_hold || (cnt_q != STRETCH_CNT_ZERO);
    end

    always_ff @(posedge i_sys_clk or negedge i_async_rst_n) begin
        if (!i_async_rst_n) begin
            cnt_q <= STRETCH_HOLD_CYC;
            active_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            active_q <= active_d;
        end
    end

    assign o_active = active_q;
endmodule

/* chip_reset_sequencer.sv */
// chip reset and clock-start sequencer: combines supply, debugger, test-port and
// watchdog reset sources and starts the two PLLs
// assumes reset pins are asynchronous and held low at least their minimum widths
//
// Functional notes
// R1 - two PLLs synthesise clocks from 32 MHz
// R2 - supply reset asserts chip reset asynchronously
// R3 - supply reset clears everything, clock system too
// R4 - only supply reset halts clock generation
// R5 - supervisor holds reset over 50 us, lock
// R6 - no test-port traffic during supply reset
// R7 - debugger reset clears logic, clocks keep running
// R8 - test port stays usable in debugger reset
// R9 - debugger reset only when running, over 10 ns
// R10 - internal resets stretched under 173.6 ns
// R11 - undriven debugger reset pin reads inactive
// R12 - watchdog counts period, expiry raises event
// R13 - watchdog event resets chip only when enabled
// R14 - watchdog cause flag survives the restart
// R15 - test-port reset clears trace logic only
// R16 - supply reset also clears trace logic
// R17 - stretched reset releases on a clock edge
`timescale 1ns/10ps
module chip_reset_sequencer #(
    parameter int unsigned LOCK_TIMEOUT_CYC = chip_reset_pkg::PLL_LOCK_MAX_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_supply_reset_n,
    input wire logic i_debugger_system_reset_in_n,
    input wire logic i_debugger_system_reset_in_driven,
    input wire logic i_test_port_reset_n,
    input wire logic [chip_reset_pkg::PLL_COUNT-1:0] i_pll_lock,
    input wire logic i_watchdog_start,
    input wire logic i_watchdog_retrigger,
    input wire logic [chip_reset_pkg::WDOG_CNT_W-1:0] i_watchdog_period,
    input wire logic i_watchdog_reset_enable,
    input wire logic i_watchdog_cause_clear,
    output logic [chip_reset_pkg::PLL_COUNT-1:0] o_pll_enable,
    output logic [chip_reset_pkg::PLL_COUNT-1:0] o_pll_locked,
    output logic o_pll_lock_error,
    output logic o_clock_system_reset,
    output logic o_chip_reset,
    output logic o_trace_reset,
    output logic o_test_port_enable,
    output logic o_watchdog_event,
    output logic o_watchdog_cause_flag,
    output chip_reset_pkg::seq_state_t o_sequence_state
);
    import chip_reset_pkg::*;

    logic supply_n;
    logic debugger_n;
    logic core_async_n;
    logic trace_async_n;
    logic supply_active;
    logic debugger_active;
    logic core_hold;
    logic wdog_req_q;
    logic wdog_req_d;

    // pad pull-up: an undriven pin resolves high, so it can never hold reset
    assign debugger_n = i_debugger_system_reset_in_n | ~i_debugger_system_reset_in_driven; // see R11
    assign supply_n = i_supply_reset_n;
    // either pin drops the core reset at once, no clock needed
    assign core_async_n = supply_n & debugger_n; // see R2 see R7
    // trace logic sees only its own pin and the supply reset
    assign trace_async_n = supply_n & i_test_port_reset_n; // see R15 see R16

    level_release_sync u_sync_supply (
        .i_sys_clk(i_sys_clk),
        .i_async_rst_n(supply_n),
        .o_active(supply_active)
    );

    level_release_sync u_sync_debugger (
        .i_sys_clk(i_sys_clk),
        .i_async_rst_n(debugger_n),
        .o_active(debugger_active)
    );

    // trace reset leaves on a clock edge, two edges after the later pin release
    level_release_sync u_sync_trace (
        .i_sys_clk(i_sys_clk),
        .i_async_rst_n(trace_async_n),
        .o_active(o_trace_reset)
    ); // see R15 see R16

    // clock system: supply reset is the only source that touches it
    release_stretch u_stretch_clock (
        .i_sys_clk(i_sys_clk),
        .i_async_rst_n(supply_n),
        .i_hold(supply_active),
        .o_active(o_clock_system_reset)
    ); // see R3 see R4 see R10 see R17

    assign core_hold = supply_active | debugger_active | wdog_req_q | i_sys_rst;

    release_stretch u_stretch_core (
        .i_sys_clk(i_sys_clk),
        .i_async_rst_n(core_async_n),
        .i_hold(core_hold),
        .o_active(o_chip_reset)
    ); // see R2 see R3 see R7 see R10 see R13 see R17

    // PLL enables: stopped while supply reset is low, untouched by other sources
    logic [PLL_COUNT-1:0] pll_enable_q;
    logic [PLL_COUNT-1:0] pll_enable_d;

    always_comb begin
        pll_enable_d = supply_active ? '0 : '1; // see R1 see R4
    end

    always_ff @(posedge i_sys_clk or negedge supply_n) begin
        if (!supply_n) begin
            pll_enable_q <= '0;
        end else begin
            pll_enable_q <= pll_enable_d;
        end
    end

    assign o_pll_enable = pll_enable_q;

    // lock indications come from the PLL macros, so they are synchronised
    logic [PLL_COUNT-1:0] lock_meta_q;
    logic [PLL_COUNT-1:0] lock_sync_q;
    logic [PLL_COUNT-1:0] locked_q;
    logic [PLL_COUNT-1:0] lock_meta_d;
    logic [PLL_COUNT-1:0] lock_sync_d;
    logic [PLL_COUNT-1:0] locked_d;

    genvar gi;
    generate
        for (gi = 0; gi < PLL_COUNT; gi++) begin : g_pll
            always_comb begin
                lock_meta_d[gi] = i_pll_lock[gi];
                lock_sync_d[gi] = lock_meta_q[gi];
                locked_d[gi] = lock_sync_q[gi] & pll_enable_q[gi]; // see R1
            end

            always_ff @(posedge i_sys_clk or negedge supply_n) begin
                if (!supply_n) begin
                    lock_meta_q[gi] <= 1'b0;
                    lock_sync_q[gi] <= 1'b0;
                    locked_q[gi] <= 1'b0;
                end else begin
                    lock_meta_q[gi] <= lock_meta_d[gi];
                    lock_sync_q[gi] <= lock_sync_d[gi];
                    locked_q[gi] <= locked_d[gi];
                end
            end
        end
    endgenerate

    assign o_pll_locked = locked_q;

    // lock watch: flags a PLL that misses its lock time after being started;
    // the supervisor should have covered this, so it only reports
    logic [LOCK_CNT_W-1:0] lock_cnt_q;
    logic [LOCK_CNT_W-1:0] lock_cnt_d;
    logic lock_err_q;
    logic lock_err_d;
    logic lock_limit;

    assign lock_limit = (lock_cnt_q == LOCK_CNT_W'(LOCK_TIMEOUT_CYC));

    always_comb begin
        lock_cnt_d = lock_cnt_q;
        lock_err_d = lock_err_q;
        if (!(&pll_enable_q) || (&locked_q)) begin
            lock_cnt_d = LOCK_CNT_RST;
        end else if (!lock_limit) begin
            lock_cnt_d = lock_cnt_q + 16'h0001;
        end else begin
            lock_err_d = 1'b1; // see R5
        end
    end

    always_ff @(posedge i_sys_clk or negedge supply_n) begin
        if (!supply_n) begin
            lock_cnt_q <= LOCK_CNT_RST;
            lock_err_q <= 1'b0;
        end else begin
            lock_cnt_q <= lock_cnt_d;
            lock_err_q <= lock_err_d;
        end
    end

    assign o_pll_lock_error = lock_err_q;

    // test-access port: off only during supply reset, on through debugger reset
    logic tap_en_q;
    logic tap_en_d;

    always_comb begin
        tap_en_d = ~supply_active; // see R6 see R8
    end

    always_ff @(posedge i_sys_clk or negedge supply_n) begin
        if (!supply_n) begin
            tap_en_q <= 1'b0;
        end else begin
            tap_en_q <= tap_en_d;
        end
    end

    assign o_test_port_enable = tap_en_q;

    // watchdog counter, part of the core reset domain
    logic [WDOG_CNT_W-1:0] wdog_cnt_q;
    logic [WDOG_CNT_W-1:0] wdog_cnt_d;
    logic wdog_event_q;
    logic wdog_event_d;
    logic wdog_expire;

    // a retrigger in the expiry cycle still counts as in time
    assign wdog_expire = i_watchdog_start && !i_watchdog_retrigger
        && (wdog_cnt_q == i_watchdog_period); // see R12

    always_comb begin
        wdog_cnt_d = wdog_cnt_q;
        wdog_event_d = 1'b0;
        wdog_req_d = wdog_req_q;
        if (o_chip_reset) begin
            wdog_cnt_d = WDOG_CNT_RST;
            wdog_req_d = 1'b0;
        end else if (!i_watchdog_start || i_watchdog_retrigger) begin
            wdog_cnt_d = WDOG_CNT_RST;
        end else if (wdog_expire) begin
            wdog_cnt_d = WDOG_CNT_RST;
            wdog_event_d = 1'b1; // see R12
            wdog_req_d = i_watchdog_reset_enable; // see R13
        end else begin
            wdog_cnt_d = wdog_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge i_sys_clk or negedge core_async_n) begin
        if (!core_async_n) begin
            wdog_cnt_q <= WDOG_CNT_RST;
            wdog_event_q <= 1'b0;
            wdog_req_q <= 1'b0;
        end else begin
            wdog_cnt_q <= wdog_cnt_d;
            wdog_event_q <= wdog_event_d;
            wdog_req_q <= wdog_req_d;
        end
    end

    assign o_watchdog_event = wdog_event_q;

    // cause flag lives on the supply reset alone so the watchdog restart keeps it;
    // a debugger reset or software clear drops it, a new enabled expiry wins over the software clear only
    logic cause_q;
    logic cause_d;

    always_comb begin
        cause_d = cause_q;
        if (wdog_expire && i_watchdog_reset_enable && !o_chip_reset) begin
            cause_d = 1'b1; // see R14
        end else if (i_watchdog_cause_clear || debugger_active) begin
            cause_d = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge supply_n) begin
        if (!supply_n) begin
            cause_q <= 1'b0;
        end else begin
            cause_q <= cause_d;
        end
    end

    assign o_watchdog_cause_flag = cause_q;

    // sequence state for observation: power hold, core hold, run
    seq_state_t state_q;
    seq_state_t state_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SEQ_POWER_HOLD: begin
                if (!o_clock_system_reset) begin
                    state_d = SEQ_CORE_HOLD;
                end
            end
            SEQ_CORE_HOLD: begin
                if (!o_chip_reset) begin
                    state_d = SEQ_RUN; // see R17
                end
            end
            SEQ_RUN: begin
                if (o_chip_reset) begin
                    state_d = SEQ_CORE_HOLD;
                end
            end
            default: begin
                state_d = SEQ_POWER_HOLD;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge supply_n) begin
        if (!supply_n) begin
            state_q <= SEQ_POWER_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_sequence_state = state_q;
endmodule

/* chip_reset_sequencer_asserts.sv */
// checker: port-level timing of the reset sequencer
// assumes pins change at falling edges; bound at the foot
`timescale 1ns/10ps
module chip_reset_sequencer_asserts #(
    parameter int unsigned LOCK_TIMEOUT_CYC = 20
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_supply_reset_n,
    input wire logic i_debugger_system_reset_in_n,
    input wire logic i_debugger_system_reset_in_driven,
    input wire logic i_test_port_reset_n,
    input wire logic [chip_reset_pkg::PLL_COUNT-1:0] i_pll_lock,
    input wire logic i_watchdog_start,
    input wire logic i_watchdog_retrigger,
    input wire logic [chip_reset_pkg::WDOG_CNT_W-1:0] i_watchdog_period,
    input wire logic i_watchdog_reset_enable,
    input wire logic i_watchdog_cause_clear,
    input wire logic [chip_reset_pkg::PLL_COUNT-1:0] o_pll_enable,
    input wire logic [chip_reset_pkg::PLL_COUNT-1:0] o_pll_locked,
    input wire logic o_pll_lock_error,
    input wire logic o_clock_system_reset,
    input wire logic o_chip_reset,
    input wire logic o_trace_reset,
    input wire logic o_test_port_enable,
    input wire logic o_watchdog_event,
    input wire logic o_watchdog_cause_flag,
    input wire chip_reset_pkg::seq_state_t o_sequence_state
);
    import chip_reset_pkg::*;
    wire dbg_on = i_debugger_system_reset_in_driven && !i_debugger_system_reset_in_n;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    a_supply_all: assert property (!i_supply_reset_n |-> o_chip_reset
        && o_clock_system_reset && o_trace_reset && o_pll_enable == '0 && !o_test_port_enable)
        else $error("supply reset not applied");
    a_dbg_core: assert property (dbg_on && i_supply_reset_n && !o_clock_system_reset
        |-> o_chip_reset && o_test_port_enable && o_pll_enable == '1)
        else $error("debugger reset wrong");
    a_trst_trace: assert property (!i_test_port_reset_n |-> o_trace_reset)
        else $error("trace reset missing");
    a_supply_stretch: assert property ($rose(i_supply_reset_n)
        |-> ##16 (o_chip_reset && o_clock_system_reset) ##1 !o_chip_reset)
        else $error("supply stretch wrong");
    a_dbg_stretch: assert property ($rose(i_debugger_system_reset_in_n)
        && $past(i_debugger_system_reset_in_driven) && i_supply_reset_n
        |-> ##16 o_chip_reset ##1 !o_chip_reset)
        else $error("debugger stretch wrong");
    a_trace_release: assert property ($rose(i_supply_reset_n) && i_test_port_reset_n
        |-> ##1 o_trace_reset ##1 !o_trace_reset)
        else $error("trace release wrong");
    a_pll_start: assert property ($rose(i_supply_reset_n)
        |-> ##2 !o_test_port_enable ##1 (o_pll_enable == '1 && o_test_port_enable))
        else $error("clock start wrong");
    a_lock_gated: assert property ((o_pll_locked & ~o_pll_enable) == '0)
        else $error("lock without enable");
    a_wd_reset: assert property (o_watchdog_event && i_watchdog_reset_enable
        |-> o_watchdog_cause_flag ##1 o_chip_reset)
        else $error("watchdog reset missing");
    a_wd_quiet: assert property (o_watchdog_event && !i_watchdog_reset_enable
        |-> !$rose(o_watchdog_cause_flag) ##1 !o_chip_reset)
        else $error("disabled watchdog reset");
    a_wd_pulse: assert property (o_watchdog_event |=> !o_watchdog_event)
        else $error("event longer than a cycle");
    a_flag_keep: assert property (o_watchdog_cause_flag && i_supply_reset_n
        && !o_chip_reset && !i_watchdog_cause_clear |=> o_watchdog_cause_flag)
        else $error("cause flag lost");
endmodule
bind chip_reset_sequencer chip_reset_sequencer_asserts #(
    .LOCK_TIMEOUT_CYC(LOCK_TIMEOUT_CYC)) u_asserts (.*);

/* reset_partner_model.sv */
// model of the supervisor, the debugger pins and the two PLL lock outputs
// assumes bench requests change at falling edges; pins move one falling edge later
`timescale 1ns/10ps
module reset_partner_model #(
    parameter int SUP_MIN = 8,
    parameter int LOCK_DLY = 4
) (
    input wire logic i_sys_clk,
    input wire logic [1:0] i_pll_enable,
    input wire logic i_por_req,
    input wire logic i_dbg_req,
    input wire logic i_dbg_float,
    input wire logic i_trst_req,
    input wire logic i_lock_hold,
    output logic o_supply_reset_n = 1'b0,
    output logic o_dbg_reset_n = 1'b1,
    output logic o_dbg_driven = 1'b1,
    output logic o_trst_n = 1'b1,
    output logic [1:0] o_pll_lock
);
    int low_cnt = 0;
    int lock_cnt = 0;
    // scaled minimum width; real supervisor holds tens of microseconds
    always @(negedge i_sys_clk) begin
        if (!o_supply_reset_n && low_cnt < SUP_MIN) low_cnt <= low_cnt + 1;
        if (o_supply_reset_n) low_cnt <= 0;
        if (i_por_req) o_supply_reset_n <= 1'b0;
        else if (low_cnt >= SUP_MIN) o_supply_reset_n <= 1'b1;
        // floating pin shows junk low; only the pull-up makes it inactive
        // pin and driven flag never move on one edge, so no false low pulse appears
        o_dbg_reset_n <= (i_dbg_float && !o_dbg_driven) ? 1'b0
            : !(i_dbg_req && o_supply_reset_n);
        o_dbg_driven <= !i_dbg_float && (o_dbg_driven || o_dbg_reset_n);
        o_trst_n <= !i_trst_req;
        lock_cnt <= (i_pll_enable == 2'h3) ? lock_cnt + 1 : 0;
    end
    assign o_pll_lock = i_pll_enable & {2{lock_cnt >= LOCK_DLY && !i_lock_hold}};
endmodule

/* chip_reset_sequencer_tb.sv */
// testbench: pin resets, stretch, clock start and watchdog of the sequencer
// assumes the partner model drives all reset and lock pins
`timescale 1ns/10ps
module chip_reset_sequencer_tb;
    import chip_reset_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_supply_reset_n, i_debugger_system_reset_in_n, i_debugger_system_reset_in_driven;
    logic i_test_port_reset_n, i_watchdog_start = 1'b0, i_watchdog_retrigger = 1'b0;
    logic [PLL_COUNT-1:0] i_pll_lock, o_pll_enable, o_pll_locked;
    logic [WDOG_CNT_W-1:0] i_watchdog_period = 16'h0003;
    logic i_watchdog_reset_enable = 1'b0, i_watchdog_cause_clear = 1'b0;
    logic o_pll_lock_error, o_clock_system_reset, o_chip_reset, o_trace_reset;
    logic o_test_port_enable, o_watchdog_event, o_watchdog_cause_flag;
    seq_state_t o_sequence_state;
    logic por = 1'b1, dbg = 1'b0, flt = 1'b0, trst = 1'b0, hold = 1'b1, ev;
    int failures = 0;
    int n_tests = 0;
    int n;
    always #5 i_sys_clk = ~i_sys_clk;
    chip_reset_sequencer #(.LOCK_TIMEOUT_CYC(20)) DUT (.*);
    reset_partner_model u_partner (.i_sys_clk(i_sys_clk), .i_pll_enable(o_pll_enable),
        .i_por_req(por), .i_dbg_req(dbg), .i_dbg_float(flt), .i_trst_req(trst),
        .i_lock_hold(hold), .o_supply_reset_n(i_supply_reset_n),
        .o_dbg_reset_n(i_debugger_system_reset_in_n),
        .o_dbg_driven(i_debugger_system_reset_in_driven), .o_trst_n(i_test_port_reset_n),
        .o_pll_lock(i_pll_lock));
    task automatic end_sim();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic step(input int c);
        repeat (c) @(negedge i_sys_clk);
        #1;
    endtask
    // counts edges from pin release up to the edge that drops chip reset
    task automatic wait_rel();
        n = 0;
        for (int k = 0; k < 300 && (n == 0 || o_chip_reset); k++) begin
            @(posedge i_sys_clk);
            #1;
            if (i_supply_reset_n && i_debugger_system_reset_in_n) n++;
        end
        if (o_chip_reset) begin
            failures++;
            end_sim();
        end
        check(16'(n), 16'(STRETCH_TOTAL_CYC));
        check(16'(n * 10 < 174), 16'h0001);
    endtask
    task automatic wait_ev();
        n = 0;
        do begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end while (!o_watchdog_event && n < 50);
        if (!o_watchdog_event) begin
            failures++;
            end_sim();
        end
    endtask
    task automatic t_lock_err();
        por <= 1'b0;
        wait_rel();
        step(40);
        check({o_pll_lock_error, o_pll_locked}, 16'h0004);
        $display("lock error test done");
    endtask
    task automatic t_por();
        hold <= 1'b0;
        por <= 1'b1;
        step(1);
        check({o_chip_reset, o_clock_system_reset, o_trace_reset, o_pll_enable,
            o_test_port_enable, o_sequence_state}, 16'h00E0);
        por <= 1'b0;
        wait_rel();
        step(10);
        check({o_pll_lock_error, o_pll_locked}, 16'h0003);
        check(o_sequence_state, SEQ_RUN);
        $display("supply reset test done");
    endtask
    task automatic t_dbg();
        dbg <= 1'b1;
        step(2);
        check({o_chip_reset, o_clock_system_reset, o_pll_enable, o_test_port_enable,
            o_sequence_state}, 16'h005D);
        dbg <= 1'b0;
        wait_rel();
        flt <= 1'b1;
        step(6);
        check({o_chip_reset, o_sequence_state}, 16'h0003);
        flt <= 1'b0;
        step(3);
        $display("debugger reset test done");
    endtask
    task automatic t_trst();
        trst <= 1'b1;
        step(2);
        check({o_trace_reset, o_chip_reset, o_clock_system_reset}, 16'h0004);
        trst <= 1'b0;
        step(4);
        check(o_trace_reset, 16'h0000);
        $display("test port reset test done");
    endtask
    task automatic t_wdog();
        @(negedge i_sys_clk) i_watchdog_start <= 1'b1;
        wait_ev();
        check(16'(n), i_watchdog_period + 16'h0001);
        step(2);
        check({o_watchdog_cause_flag, o_chip_reset}, 16'h0000);
        ev = 1'b0;
        for (int k = 0; k < 12; k++) begin
            @(negedge i_sys_clk) i_watchdog_retrigger <= (k % 3 == 0);
            ev = ev | o_watchdog_event;
        end
        check(ev, 1'b0);
        @(negedge i_sys_clk) i_watchdog_reset_enable <= 1'b1;
        wait_ev();
        @(negedge i_sys_clk) i_watchdog_start <= 1'b0;
        step(1);
        check({o_watchdog_cause_flag, o_chip_reset}, 16'h0003);
        step(25);
        check({o_watchdog_cause_flag, o_chip_reset}, 16'h0002);
        i_watchdog_cause_clear <= 1'b1;
        step(1);
        i_watchdog_cause_clear <= 1'b0;
        step(1);
        check(o_watchdog_cause_flag, 16'h0000);
        $display("watchdog test done");
    endtask
    initial begin
        step(10);
        i_sys_rst <= 1'b0;
        t_lock_err();
        t_por();
        t_dbg();
        t_trst();
        t_wdog();
        end_sim();
    end
endmodule
